// ==== hw/eps_pkg.sv ====
// Constants for the e-paper panel setting register block
`default_nettype none
package eps_pkg;
  // --------------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------------
  localparam logic [7:0] CMD_PANEL_SETTING = 8'h00;
  localparam int         PARAM_COUNT       = 2;

  // --------------------------------------------------------------------------
  // Reset values of both parameter bytes
  // --------------------------------------------------------------------------
  localparam logic [7:0] FIRST_RESET  = 8'h0F;
  localparam logic [7:0] SECOND_RESET = 8'h09;

  // --------------------------------------------------------------------------
  // Field positions, first parameter
  // --------------------------------------------------------------------------
  localparam int RES_MSB    = 7;
  localparam int RES_LSB    = 6;
  localparam int PST_BIT    = 5;
  localparam int GATE_BIT   = 3;
  localparam int SOURCE_BIT = 2;
  localparam int SHD_BIT    = 1;
  localparam int SOFT_BIT   = 0;
  // Field position, second parameter
  localparam int WTS_BIT    = 7;
  // Mask of first-parameter bits that are kept (bit 4 unused)
  localparam logic [7:0] FIRST_MASK = 8'hEF;

  // --------------------------------------------------------------------------
  // Resolution encodings and active area sizes
  // --------------------------------------------------------------------------
  localparam logic [1:0] RES_400X300 = 2'h0;
  localparam logic [1:0] RES_300X300 = 2'h1;
  localparam logic [1:0] RES_256X256 = 2'h2;
  localparam logic [1:0] RES_128X128 = 2'h3;
  localparam int         IDX_W       = 9;
  localparam logic [8:0] SIZE_400    = 9'h190;
  localparam logic [8:0] SIZE_300    = 9'h12C;
  localparam logic [8:0] SIZE_256    = 9'h100;
  localparam logic [8:0] SIZE_128    = 9'h080;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int PWR_SWITCH_NS  = 1000;
  localparam int PWR_SWITCH_CYC = (PWR_SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWR_CNT_W      = 8;

  // Frame sequencer states, Gray along idle -> pre-period -> scan
  typedef enum logic [1:0] {
    EPS_IDLE = 2'b00,
    EPS_PRE  = 2'b01,
    EPS_SCAN = 2'b11
  } eps_frame_t;
endpackage
`default_nettype wire

// ==== hw/eps_idx_walk.sv ====
// Index walker: steps an index up or down across an active range
`default_nettype none
module eps_idx_walk (
  input  wire logic       i_clk_sys,
  input  wire logic       i_srst,
  input  wire logic       i_start,
  input  wire logic       i_step,
  input  wire logic       i_ascending,
  input  wire logic [8:0] i_count,
  output logic      [8:0] o_index,
  output logic            o_busy,
  output logic            o_done
);
  logic [8:0] last_idx;
  logic       at_end;

  // Final index depends on direction: top of range going up, zero going down
  assign last_idx = i_count - 9'h001;
  assign at_end   = i_ascending ? (o_index == last_idx) : (o_index == 9'h000);

  // --------------------------------------------------------------------------
  // Walk
  // --------------------------------------------------------------------------
  // Start wins over step so a restart mid-walk is always clean
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_index <= 9'h000;
      o_busy  <= 1'b0;
      o_done  <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        o_index <= i_ascending ? 9'h000 : last_idx;
        o_busy  <= 1'b1;
      end else if (i_step && o_busy) begin
        if (at_end) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else if (i_ascending) begin
          o_index <= o_index + 9'h001;
        end else begin
          o_index <= o_index - 9'h001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== hw/eps_panel_setting.sv ====
// Panel setting register with command decode and the scan controls it steers
//
// Functional notes
// R1: Each byte carries a command/data tag and is decoded by that tag.
// R2: Each byte belongs to either a write cycle or a read cycle.
// R3: Command byte 00h selects the panel setting register and the next two write data bytes load it.
// R4: First-parameter bits 7:6 pick 300x300, 256x256 or 128x128 for codes 01, 10, 11.
// R5: The resolution field resets to 00, the full 400x300 area.
// R6: With bit 5 set, power switching runs in an extra period before scanning starts.
// R7: With bit 5 clear, the reset value, power switching runs inside the scanning period.
// R8: With bit 3 clear, gates scan from the highest index down to zero.
// R9: With bit 3 set, the reset value, gates scan from zero up to the highest index.
// R10: With bit 2 clear, the first data goes to the highest source and the last to source zero.
// R11: With bit 2 set, the reset value, the first data goes to source zero and proceeds upward.
// R12: Power switching timing sits at bit 5 and bit 4 is unused.
// R13: Clearing bit 1 turns the booster off, keeps registers, and holds outputs at 0 V or float.
// R14: Clearing bit 0 turns the booster off, restores all defaults and drives outputs to 0 V.
// R15: Second-parameter bit 7 selects the waveform table: 0 from OTP, 1 from registers.
// R16: A command takes effect only at the transfer's stop condition.
// R17: The host zeroes unused bits and always sends both parameters.
`default_nettype none
module eps_panel_setting (
  input  wire logic       i_clk_sys,
  input  wire logic       i_srst,
  // Byte stream from the serial command interface
  input  wire logic       i_byte_valid,
  input  wire logic [7:0] i_byte_data,
  input  wire logic       i_byte_is_cmd,
  input  wire logic       i_byte_write,
  input  wire logic       i_xfer_stop,
  // Scan engine handshakes
  input  wire logic       i_frame_req,
  input  wire logic       i_gate_step,
  input  wire logic       i_source_step,
  // Decoded settings
  output logic [1:0]      o_resolution_select,
  output logic [8:0]      o_active_width,
  output logic [8:0]      o_active_height,
  output logic            o_power_switch_timing,
  output logic            o_gate_scan_direction,
  output logic            o_source_shift_direction,
  output logic            o_booster_shutdown_n,
  output logic            o_waveform_table_source,
  output logic            o_booster_enable,
  output logic            o_outputs_hold_zero,
  output logic            o_soft_reset,
  // Frame activity
  output logic            o_power_switch,
  output logic            o_frame_busy,
  output logic [8:0]      o_gate_index,
  output logic [8:0]      o_source_index
);
  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [7:0]          first_r;
  logic [7:0]          second_r;
  logic [7:0]          stage_first_r;
  logic [7:0]          stage_second_r;
  logic [1:0]          param_cnt_r;
  logic                selected_r;
  logic                soft_req;
  logic                commit;
  eps_pkg::eps_frame_t state_r;
  logic [7:0]          pwr_cnt_r;
  logic                scan_start;
  logic                line_start;
  logic                gate_busy;
  logic                gate_done;
  logic [8:0]          gate_idx;
  logic [8:0]          src_idx;
  logic [8:0]          width_nxt;
  logic [8:0]          height_nxt;

  // --------------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------------
  // Only write-cycle bytes count; read cycles never touch this register
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      selected_r     <= 1'b0;
      param_cnt_r    <= 2'h0;
      stage_first_r  <= eps_pkg::FIRST_RESET;
      stage_second_r <= eps_pkg::SECOND_RESET;
    end else if (i_xfer_stop) begin
      selected_r  <= 1'b0;                                      // [R16]
      param_cnt_r <= 2'h0;
    end else if (i_byte_valid && i_byte_write) begin            // [R2]
      if (i_byte_is_cmd) begin                                  // [R1]
        selected_r  <= (i_byte_data == eps_pkg::CMD_PANEL_SETTING); // [R3]
        param_cnt_r <= 2'h0;
      end else if (selected_r && param_cnt_r < 2'(eps_pkg::PARAM_COUNT)) begin
        if (param_cnt_r == 2'h0) begin
          stage_first_r <= i_byte_data & eps_pkg::FIRST_MASK; // [R12]
        end else begin
          stage_second_r <= i_byte_data;                      // [R3]
        end
        param_cnt_r <= param_cnt_r + 2'h1;
      end
    end
  end

  // Load happens only at the stop; a short transfer updates what it carried
  assign commit   = i_xfer_stop && selected_r && (param_cnt_r != 2'h0); // [R16]
  assign soft_req = commit && !stage_first_r[eps_pkg::SOFT_BIT];        // [R14]

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  // Soft default restores both bytes; a set default bit itself has no effect
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || soft_req) begin
      first_r  <= eps_pkg::FIRST_RESET;                         // [R5] [R14]
      second_r <= eps_pkg::SECOND_RESET;
    end else if (commit) begin
      first_r <= stage_first_r;
      if (param_cnt_r == 2'(eps_pkg::PARAM_COUNT)) begin
        second_r <= stage_second_r;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Decoded outputs
  // --------------------------------------------------------------------------
  always_comb begin
    unique case (first_r[eps_pkg::RES_MSB:eps_pkg::RES_LSB])   // [R4]
      eps_pkg::RES_400X300: begin
        width_nxt  = eps_pkg::SIZE_400;
        height_nxt = eps_pkg::SIZE_300;
      end
      eps_pkg::RES_300X300: begin
        width_nxt  = eps_pkg::SIZE_300;
        height_nxt = eps_pkg::SIZE_300;
      end
      eps_pkg::RES_256X256: begin
        width_nxt  = eps_pkg::SIZE_256;
        height_nxt = eps_pkg::SIZE_256;
      end
      eps_pkg::RES_128X128: begin
        width_nxt  = eps_pkg::SIZE_128;
        height_nxt = eps_pkg::SIZE_128;
      end
    endcase
  end

  // Registered copies so every output leaves from a flip-flop
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_resolution_select      <= eps_pkg::RES_400X300;
      o_active_width           <= eps_pkg::SIZE_400;
      o_active_height          <= eps_pkg::SIZE_300;
      o_power_switch_timing    <= eps_pkg::FIRST_RESET[eps_pkg::PST_BIT];
      o_gate_scan_direction    <= eps_pkg::FIRST_RESET[eps_pkg::GATE_BIT];
      o_source_shift_direction <= eps_pkg::FIRST_RESET[eps_pkg::SOURCE_BIT];
      o_booster_shutdown_n     <= eps_pkg::FIRST_RESET[eps_pkg::SHD_BIT];
      o_waveform_table_source  <= eps_pkg::SECOND_RESET[eps_pkg::WTS_BIT];
      o_booster_enable         <= 1'b0;
      o_outputs_hold_zero      <= 1'b1;
      o_soft_reset             <= 1'b0;
    end else begin
      o_resolution_select      <= first_r[eps_pkg::RES_MSB:eps_pkg::RES_LSB]; // [R4]
      o_active_width           <= width_nxt;
      o_active_height          <= height_nxt;
      o_power_switch_timing    <= first_r[eps_pkg::PST_BIT];    // [R12]
      o_gate_scan_direction    <= first_r[eps_pkg::GATE_BIT];
      o_source_shift_direction <= first_r[eps_pkg::SOURCE_BIT];
      o_booster_shutdown_n     <= first_r[eps_pkg::SHD_BIT];
      o_waveform_table_source  <= second_r[eps_pkg::WTS_BIT];   // [R15]
      // Booster off for shutdown or for the cycle of a soft default
      o_booster_enable         <= first_r[eps_pkg::SHD_BIT] && !soft_req; // [R13] [R14]
      o_outputs_hold_zero      <= !first_r[eps_pkg::SHD_BIT] || soft_req; // [R13] [R14]
      o_soft_reset             <= soft_req;                     // [R14]
    end
  end

  // --------------------------------------------------------------------------
  // Frame sequencer
  // --------------------------------------------------------------------------
  // A frame cannot start while the booster is off; the request is dropped
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_r        <= eps_pkg::EPS_IDLE;
      pwr_cnt_r      <= 8'h00;
      o_power_switch <= 1'b0;
    end else begin
      unique case (state_r)
        eps_pkg::EPS_IDLE: begin
          if (i_frame_req && first_r[eps_pkg::SHD_BIT]) begin
            pwr_cnt_r      <= 8'(eps_pkg::PWR_SWITCH_CYC - 1);
            o_power_switch <= 1'b1;
            state_r        <= first_r[eps_pkg::PST_BIT] ? eps_pkg::EPS_PRE  // [R6]
                                                        : eps_pkg::EPS_SCAN; // [R7]
          end
        end
        eps_pkg::EPS_PRE: begin
          // Scanning waits out the whole inserted power period
          if (pwr_cnt_r == 8'h00) begin
            o_power_switch <= 1'b0;
            state_r        <= eps_pkg::EPS_SCAN;                // [R6]
          end else begin
            pwr_cnt_r <= pwr_cnt_r - 8'h01;
          end
        end
        eps_pkg::EPS_SCAN: begin
          // Power switching overlaps the first cycles of the scan
          if (pwr_cnt_r == 8'h00) begin
            o_power_switch <= 1'b0;                             // [R7]
          end else begin
            pwr_cnt_r <= pwr_cnt_r - 8'h01;
          end
          if (gate_done || !first_r[eps_pkg::SHD_BIT]) begin
            o_power_switch <= 1'b0;
            state_r        <= eps_pkg::EPS_IDLE;
          end
        end
        default: begin
          state_r        <= eps_pkg::EPS_IDLE;
          o_power_switch <= 1'b0;
        end
      endcase
    end
  end

  // Scan begins on entering the scan state; each gate line restarts sources
  assign scan_start = (state_r != eps_pkg::EPS_SCAN) &&
                      ((state_r == eps_pkg::EPS_IDLE && i_frame_req &&
                        first_r[eps_pkg::SHD_BIT] && !first_r[eps_pkg::PST_BIT]) ||
                       (state_r == eps_pkg::EPS_PRE && pwr_cnt_r == 8'h00));
  assign line_start = scan_start || (i_gate_step && gate_busy);

  // --------------------------------------------------------------------------
  // Gate and source walkers
  // --------------------------------------------------------------------------
  eps_idx_walk u_gate_walk (
    .i_clk_sys   (i_clk_sys),
    .i_srst      (i_srst),
    .i_start     (scan_start),
    .i_step      (i_gate_step),
    .i_ascending (first_r[eps_pkg::GATE_BIT]),                  // [R8] [R9]
    .i_count     (height_nxt),
    .o_index     (gate_idx),
    .o_busy      (gate_busy),
    .o_done      (gate_done)
  );

  eps_idx_walk u_source_walk (
    .i_clk_sys   (i_clk_sys),
    .i_srst      (i_srst),
    .i_start     (line_start),
    .i_step      (i_source_step),
    .i_ascending (first_r[eps_pkg::SOURCE_BIT]),                // [R10] [R11]
    .i_count     (width_nxt),
    .o_index     (src_idx),
    .o_busy      (),
    .o_done      ()
  );

  // Walker indices already come from flip-flops; busy is retimed here
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_frame_busy <= 1'b0;
    end else begin
      o_frame_busy <= (state_r != eps_pkg::EPS_IDLE);
    end
  end

  assign o_gate_index   = gate_idx;
  assign o_source_index = src_idx;
endmodule
`default_nettype wire

// ==== testbench/eps_panel_setting_assertions.sv ====
// Checker for the panel setting register block, bound to its top module
`default_nettype none
module eps_panel_setting_assertions (
  input wire logic       i_clk_sys,
  input wire logic       i_srst,
  input wire logic       i_xfer_stop,
  input wire logic       i_frame_req,
  input wire logic [1:0] o_resolution_select,
  input wire logic [8:0] o_active_width,
  input wire logic [8:0] o_active_height,
  input wire logic       o_power_switch_timing,
  input wire logic       o_gate_scan_direction,
  input wire logic       o_booster_shutdown_n,
  input wire logic       o_booster_enable,
  input wire logic       o_outputs_hold_zero,
  input wire logic       o_soft_reset,
  input wire logic       o_power_switch,
  input wire logic       o_frame_busy,
  input wire logic [8:0] o_gate_index
);
  logic [7:0] pw_cnt_r;
  // Width of the power switching window, too long for a repetition
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      pw_cnt_r <= 8'h00;
    end else if (o_power_switch) begin
      pw_cnt_r <= pw_cnt_r + 8'h01;
    end else begin
      pw_cnt_r <= 8'h00;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  property p_res_full;
    o_resolution_select == eps_pkg::RES_400X300 |->
      o_active_width == eps_pkg::SIZE_400 && o_active_height == eps_pkg::SIZE_300;
  endproperty
  a_res_full: assert property (p_res_full) else $error("full area size wrong");
  property p_res_small;
    o_resolution_select == eps_pkg::RES_128X128 |->
      o_active_width == eps_pkg::SIZE_128 && o_active_height == eps_pkg::SIZE_128;
  endproperty
  a_res_small: assert property (p_res_small) else $error("small area size wrong");
  // Settings may only move one cycle after a stop
  property p_hold;
    !$past(i_xfer_stop, 2) && !$past(i_srst, 2) |-> $stable(o_resolution_select) &&
      $stable(o_gate_scan_direction) && $stable(o_power_switch_timing);
  endproperty
  a_hold: assert property (p_hold) else $error("setting moved without stop");
  property p_start;
    i_frame_req && !o_frame_busy && !o_power_switch && o_booster_shutdown_n |=> o_power_switch;
  endproperty
  a_start: assert property (p_start) else $error("power switch did not start");
  property p_pw_len;
    $fell(o_power_switch) && o_booster_shutdown_n |-> pw_cnt_r == 8'(eps_pkg::PWR_SWITCH_CYC);
  endproperty
  a_pw_len: assert property (p_pw_len) else $error("power switch length wrong");
  property p_pst0;
    $rose(o_power_switch) && !o_power_switch_timing && !o_gate_scan_direction |->
      o_gate_index == o_active_height - 9'h001;
  endproperty
  a_pst0: assert property (p_pst0) else $error("scan not started with switch");
  property p_pst1;
    $fell(o_power_switch) && o_power_switch_timing && !o_gate_scan_direction |->
      ##[0:2] o_gate_index == o_active_height - 9'h001;
  endproperty
  a_pst1: assert property (p_pst1) else $error("scan not started after switch");
  property p_soft;
    $rose(o_soft_reset) |-> (!o_booster_enable && o_outputs_hold_zero) ##1
      (o_resolution_select == eps_pkg::RES_400X300 && o_gate_scan_direction);
  endproperty
  a_soft: assert property (p_soft) else $error("soft default incomplete");
  property p_soft_one;
    o_soft_reset |=> !o_soft_reset;
  endproperty
  a_soft_one: assert property (p_soft_one) else $error("soft pulse too long");
  property p_shd;
    !o_booster_shutdown_n && !$past(o_booster_shutdown_n) |->
      !o_booster_enable && o_outputs_hold_zero;
  endproperty
  a_shd: assert property (p_shd) else $error("booster on during shutdown");
endmodule
bind eps_panel_setting eps_panel_setting_assertions u_chk (
  .i_clk_sys, .i_srst, .i_xfer_stop, .i_frame_req, .o_resolution_select,
  .o_active_width, .o_active_height, .o_power_switch_timing, .o_gate_scan_direction,
  .o_booster_shutdown_n, .o_booster_enable, .o_outputs_hold_zero, .o_soft_reset,
  .o_power_switch, .o_frame_busy, .o_gate_index
);
`default_nettype wire

// ==== testbench/eps_host_model.sv ====
// Host model driving the tagged byte stream of the command interface
`default_nettype none
module eps_host_model (
  input  wire logic       i_clk_sys,
  output logic            o_byte_valid,
  output logic [7:0]      o_byte_data,
  output logic            o_byte_is_cmd,
  output logic            o_byte_write,
  output logic            o_xfer_stop
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus: strobes low
  initial begin
    o_byte_valid = 1'b0;
    o_byte_data = 8'h00;
    o_byte_is_cmd = 1'b0;
    o_byte_write = 1'b0;
    o_xfer_stop = 1'b0;
  end
  // One tagged byte; released lines show inverted junk, not the old value
  task automatic put_byte(input logic c, input logic w, input logic [7:0] d);
    @(posedge i_clk_sys);
    #1 o_byte_valid = 1'b1;
    o_byte_data = d;
    o_byte_is_cmd = c;
    o_byte_write = w;
    @(posedge i_clk_sys);
    #1 o_byte_valid = 1'b0;
    o_byte_data = ~d;
    o_byte_is_cmd = ~c;
    o_byte_write = ~w;
  endtask
  // Stop condition closes the transfer
  task automatic stop_xfer();
    @(posedge i_clk_sys);
    #1 o_xfer_stop = 1'b1;
    @(posedge i_clk_sys);
    #1 o_xfer_stop = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the panel setting register block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        frq = 1'b0, gst = 1'b0, sst = 1'b0;
  logic        bv, bc, bw, bs;
  logic [7:0]  bd, rnd;
  logic [1:0]  res;
  logic [8:0]  wid, hgt, gix, six;
  logic        pst, gd, sd, shd, wts, ben, hz, sft, pws, busy;
  logic [16:0] notes[$];
  logic [16:0] cur, nt;
  int          err_count = 0, checked = 0, cyc = 0;
  always #5 clk = ~clk;
  eps_host_model u_host (.i_clk_sys(clk), .o_byte_valid(bv), .o_byte_data(bd),
    .o_byte_is_cmd(bc), .o_byte_write(bw), .o_xfer_stop(bs));
  eps_panel_setting u_dut (.i_clk_sys(clk), .i_srst(srst), .i_byte_valid(bv),
    .i_byte_data(bd), .i_byte_is_cmd(bc), .i_byte_write(bw), .i_xfer_stop(bs),
    .i_frame_req(frq), .i_gate_step(gst), .i_source_step(sst),
    .o_resolution_select(res), .o_active_width(wid), .o_active_height(hgt),
    .o_power_switch_timing(pst), .o_gate_scan_direction(gd),
    .o_source_shift_direction(sd), .o_booster_shutdown_n(shd),
    .o_waveform_table_source(wts), .o_booster_enable(ben), .o_outputs_hold_zero(hz),
    .o_soft_reset(sft), .o_power_switch(pws), .o_frame_busy(busy),
    .o_gate_index(gix), .o_source_index(six));
  task automatic print_verdict();
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  function automatic logic [8:0] area(input logic [1:0] r, input logic h);
    case (r)
      eps_pkg::RES_300X300: area = eps_pkg::SIZE_300;
      eps_pkg::RES_256X256: area = eps_pkg::SIZE_256;
      eps_pkg::RES_128X128: area = eps_pkg::SIZE_128;
      default: area = h ? eps_pkg::SIZE_300 : eps_pkg::SIZE_400;
    endcase
  endfunction
  // Note layout: soft flag, first byte, second byte
  task automatic cmp(input logic [16:0] n);
    chk("res", 9'(n[15:14]), 9'(res));
    chk("wid", area(n[15:14], 1'b0), wid);
    chk("hgt", area(n[15:14], 1'b1), hgt);
    chk("pst", 9'(n[13]), 9'(pst));
    chk("gd", 9'(n[11]), 9'(gd));
    chk("sd", 9'(n[10]), 9'(sd));
    chk("shd", 9'(n[9]), 9'(shd));
    chk("ben", 9'(n[9]), 9'(ben));
    chk("hz", 9'(!n[9]), 9'(hz));
    chk("sft", 9'h000, 9'(sft));
    chk("wts", 9'(n[7]), 9'(wts));
  endtask
  // Soft pulse stands right after the stop edge; settings land one edge later
  always @(posedge clk) begin
    if (bs === 1'b1 && notes.size() > 0) begin
      #2 nt = notes.pop_front();
      chk("sft", 9'(nt[16]), 9'(sft));
      if (nt[16]) begin
        chk("ben", 9'h000, 9'(ben));
        chk("hz", 9'h001, 9'(hz));
      end
      @(posedge clk);
      #2 cmp(nt);
    end
  end
  // Hang guard, far above the roughly 840 cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      print_verdict();
    end
  end
  // A clear bit 0 restores defaults and discards the second byte
  task automatic panel_setting_first(input logic [7:0] p1, input logic [7:0] p2);
    cur = p1[0] ? {1'b0, p1 & eps_pkg::FIRST_MASK, p2}
                : {1'b1, eps_pkg::FIRST_RESET, eps_pkg::SECOND_RESET};
    notes.push_back(cur);
    u_host.put_byte(1'b1, 1'b1, eps_pkg::CMD_PANEL_SETTING);
    u_host.put_byte(1'b0, 1'b1, p1);
    u_host.put_byte(1'b0, 1'b1, p2);
    u_host.stop_xfer();
  endtask
  // Downward 128-line frame; walker end and index order watched
  task automatic frame();
    repeat (3) @(posedge clk);
    #1 frq = 1'b1;
    @(posedge clk);
    #1 frq = 1'b0;
    repeat (50) @(posedge clk);
    #1 chk("pws", 9'h001, 9'(pws));
    repeat (60) @(posedge clk);
    #1 chk("pws", 9'h000, 9'(pws));
    chk("gix", eps_pkg::SIZE_128 - 9'h001, gix);
    chk("six", eps_pkg::SIZE_128 - 9'h001, six);
    sst = 1'b1;
    @(posedge clk);
    #1 sst = 1'b0;
    @(posedge clk);
    #1 chk("six", eps_pkg::SIZE_128 - 9'h002, six);
    repeat (128) begin
      gst = 1'b1;
      @(posedge clk);
      #1 gst = 1'b0;
      @(posedge clk);
      #1;
    end
    repeat (3) @(posedge clk);
    #1 chk("busy", 9'h000, 9'(busy));
  endtask
  initial begin
    void'($urandom(32'h3EDE));
    repeat (4) @(posedge clk);
    #1 srst = 1'b0;
    repeat (2) @(posedge clk);
    #2 cmp({1'b0, eps_pkg::FIRST_RESET, eps_pkg::SECOND_RESET});
    for (int r = 0; r < 4; r++) begin
      rnd = 8'($urandom());
      panel_setting_first({2'(r), rnd[5], 1'b0, rnd[3:1], 1'b1}, 8'($urandom()) & 8'hBF);
    end
    // Non-default area and gate direction so the soft default below has work to do
    panel_setting_first(8'hC5, 8'h80);
    panel_setting_first(8'hC2, 8'h80);
    // Foreign command with data: nothing may change
    notes.push_back({1'b0, cur[15:0]});
    u_host.put_byte(1'b1, 1'b1, 8'h61);
    u_host.put_byte(1'b0, 1'b1, 8'h07);
    u_host.stop_xfer();
    // A read-cycle byte inside the write sequence is skipped
    cur = {1'b0, 8'hEF, 8'h00};
    notes.push_back(cur);
    u_host.put_byte(1'b1, 1'b1, 8'h00);
    u_host.put_byte(1'b0, 1'b0, 8'h55);
    u_host.put_byte(1'b0, 1'b1, 8'hEF);
    u_host.put_byte(1'b0, 1'b1, 8'h00);
    u_host.stop_xfer();
    for (int p = 0; p < 2; p++) begin
      panel_setting_first({2'b11, 1'(p), 5'b00011}, 8'h00);
      frame();
    end
    repeat (5) @(posedge clk);
    print_verdict();
  end
endmodule
`default_nettype wire
